/* File: include/sysref_ctrl_map.svh */
// Purpose: Offsets, field positions, reset values and constants of the
//          SYSREF and delay calibration control registers.
// Assumes: Byte-wide registers on the configuration port.
// Notes:   Definitions only.
`ifndef SYSREF_CTRL_MAP_SVH
`define SYSREF_CTRL_MAP_SVH

// Register offsets
`define SYSREF_POWER_CTRL_ADDR 8'h18
`define SYSREF_BIAS_DELAY_CTRL_ADDR 8'h19
`define CALIB_FEEDBACK_DIV_LOW_ADDR 8'h1A
`define ALIGN_DIV_CALIB_INPUT_DIV_ADDR 8'h1B

// Field positions
`define PWR_POWERDOWN_BIT 7
`define BDC_BIAS_TYPE_BIT 7
`define BDC_SCALE_HI 6
`define BDC_SCALE_LO 5
`define BDC_FBDIV_MSB_BIT 0
`define AID_ALIGN_SEL_BIT 7
`define AID_INDIV_HI 6
`define AID_INDIV_LO 0

// Field reset values
`define POWERDOWN_RST 1'h0
`define BIAS_TYPE_RST 1'h0
`define SCALE_RST 2'h0
`define FBDIV_RST 9'h010
`define INDIV_RST 7'h08
`define ALIGN_SEL_RST 1'h0

// Alignment reference divide ratios
`define ALIGN_DIV_SMALL 6'h18
`define ALIGN_DIV_LARGE 6'h30

// Number of SYSREF outputs
`define SYSREF_OUTPUTS 8

`endif

/* File: include/sysref_ctrl_pkg.sv */
// Purpose: Types shared by the SYSREF control register block.
// Assumes: Nothing beyond the map header.
// Notes:   Calibration codes change one bit from idle to start to run; run back to idle flips both bits.
package sysref_ctrl_pkg;

  // Calibration handshake state
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_START = 2'h1,
    CAL_RUN = 2'h3
  } calib_state_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_POWER = 3'h1,
    SEL_BIAS_DELAY = 3'h2,
    SEL_FB_LOW = 3'h3,
    SEL_ALIGN_IN = 3'h4
  } reg_sel_t;

endpackage

/* File: design/sysref_delay_calibration_ctrl.sv */
// Purpose: Control registers of the SYSREF path: global power-down, LVDS
//          idle bias, delay unit scale, calibration loop dividers, alignment
//          reference divider, plus the per-output SYSREF idle/toggle logic.
// Assumes: Configuration port strobes are one-cycle, synchronous to the clock;
//          the SYSREF input is already synchronous.
// Notes:   Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "sysref_ctrl_map.svh"

// Behaviour
// - Power-down bit powers down all SYSREF blocks
// - Bias 0/0: idle low, toggle after rising edge
// - Bias 0/1: static low, never toggles
// - Bias 1/0: crosspoint idle, toggle after edge
// - Bias 1/1: static crosspoint, also during events
// - Global bias affects LVDS outputs only
// - Delay step is (1 + scale) units
// - Nine-bit feedback divider split, default 16
// - Seven-bit input divider, default 8
// - Alignment select: 0 divides 24, 1 divides 48
// - Trigger starts calibration, self-clears, stores result
module sysref_delay_calibration_ctrl
  import sysref_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Configuration port
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  output logic cfg_hit_out,
  // Per-output settings from the neighbouring output registers
  input wire logic [`SYSREF_OUTPUTS-1:0] out_bias_in,
  input wire logic [`SYSREF_OUTPUTS-1:0] out_lvpecl_in,
  // Central SYSREF signal
  input wire logic sysref_in,
  // SYSREF output leg levels
  output logic [`SYSREF_OUTPUTS-1:0] sysref_output_out,
  output logic [`SYSREF_OUTPUTS-1:0] sysref_output_complement_out,
  output logic [`SYSREF_OUTPUTS-1:0] lvds_crosspoint_level_out,
  // Static controls to the analog path
  output logic sysref_global_powerdown_out,
  output logic [2:0] sysref_delay_step_units_out,
  output logic [8:0] calib_loop_feedback_divider_out,
  output logic [6:0] calib_loop_input_divider_out,
  output logic [5:0] align_ref_divide_out,
  // Delay calibration block handshake
  input wire logic calib_trigger_in,
  input wire logic calib_done_in,
  input wire logic [14:0] calib_code_in,
  output logic calib_start_out,
  output logic calib_trigger_pending_out,
  output logic [14:0] calib_result_out
);

  // Address decode, shared by the write and read paths
  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == `SYSREF_POWER_CTRL_ADDR) begin
      sel = SEL_POWER;
    end else if (addr == `SYSREF_BIAS_DELAY_CTRL_ADDR) begin
      sel = SEL_BIAS_DELAY;
    end else if (addr == `CALIB_FEEDBACK_DIV_LOW_ADDR) begin
      sel = SEL_FB_LOW;
    end else if (addr == `ALIGN_DIV_CALIB_INPUT_DIV_ADDR) begin
      sel = SEL_ALIGN_IN;
    end
    return sel;
  endfunction

  // Stored fields
  logic powerdown_q; // Global SYSREF power-down
  logic bias_type_q; // Global LVDS idle bias select
  logic [1:0] scale_q; // Delay unit scale
  logic [8:0] fbdiv_q; // Calibration loop feedback divider
  logic [6:0] indiv_q; // Calibration loop input divider
  logic align_sel_q; // Alignment reference divider select

  // SYSREF edge tracking
  logic sysref_prev_q; // Last sampled SYSREF level
  logic armed_q; // A rising edge has been seen since power-up
  logic rise;

  // Calibration state
  calib_state_t cal_state_q;

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;

  assign wr_sel = decode_addr(cfg_addr_in);
  assign rd_sel = wr_sel;
  assign rise = sysref_in && !sysref_prev_q;

  // Register writes; reserved bit positions are simply not stored
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      powerdown_q <= `POWERDOWN_RST;
      bias_type_q <= `BIAS_TYPE_RST;
      scale_q <= `SCALE_RST;
      fbdiv_q <= `FBDIV_RST;
      indiv_q <= `INDIV_RST;
      align_sel_q <= `ALIGN_SEL_RST;
    end else if (cfg_wr_in) begin
      case (wr_sel)
        SEL_POWER: begin
          powerdown_q <= cfg_wdata_in[`PWR_POWERDOWN_BIT];
        end
        SEL_BIAS_DELAY: begin
          bias_type_q <= cfg_wdata_in[`BDC_BIAS_TYPE_BIT];
          scale_q <= cfg_wdata_in[`BDC_SCALE_HI:`BDC_SCALE_LO];
          fbdiv_q[8] <= cfg_wdata_in[`BDC_FBDIV_MSB_BIT];
        end
        SEL_FB_LOW: begin
          fbdiv_q[7:0] <= cfg_wdata_in;
        end
        SEL_ALIGN_IN: begin
          align_sel_q <= cfg_wdata_in[`AID_ALIGN_SEL_BIT];
          indiv_q <= cfg_wdata_in[`AID_INDIV_HI:`AID_INDIV_LO];
        end
        default: begin
          // Unmapped address: write ignored
        end
      endcase
    end
  end

  // Read path: data one cycle after the strobe, zero when unmapped
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_rdata_out <= 8'h00;
      cfg_rvalid_out <= 1'b0;
      cfg_hit_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      cfg_hit_out <= cfg_rd_in && (rd_sel != SEL_NONE);
      if (cfg_rd_in) begin
        case (rd_sel)
          SEL_POWER: begin
            cfg_rdata_out <= {powerdown_q, 7'h00};
          end
          SEL_BIAS_DELAY: begin
            cfg_rdata_out <= {bias_type_q, scale_q, 4'h0, fbdiv_q[8]};
          end
          SEL_FB_LOW: begin
            cfg_rdata_out <= fbdiv_q[7:0];
          end
          SEL_ALIGN_IN: begin
            cfg_rdata_out <= {align_sel_q, indiv_q};
          end
          default: begin
            cfg_rdata_out <= 8'h00;
          end
        endcase
      end
    end
  end

  // Static control outputs, registered copies of the fields
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sysref_global_powerdown_out <= `POWERDOWN_RST;
      sysref_delay_step_units_out <= 3'h1;
      calib_loop_feedback_divider_out <= `FBDIV_RST;
      calib_loop_input_divider_out <= `INDIV_RST;
      align_ref_divide_out <= `ALIGN_DIV_SMALL;
    end else begin
      sysref_global_powerdown_out <= powerdown_q;
      // Step is (1 + scale) eighths of the oscillator period
      sysref_delay_step_units_out <= {1'b0, scale_q} + 3'h1;
      calib_loop_feedback_divider_out <= fbdiv_q;
      calib_loop_input_divider_out <= indiv_q;
      // Dividers are not range checked; software keeps the loop in band
      align_ref_divide_out <= align_sel_q ? `ALIGN_DIV_LARGE : `ALIGN_DIV_SMALL;
    end
  end

  // First rising edge arms toggling; power-down forgets it so the
  // outputs return to their idle level when the path comes back up
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sysref_prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      sysref_prev_q <= sysref_in;
      if (powerdown_q) begin
        armed_q <= 1'b0;
      end else if (rise) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Per-output leg levels
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sysref_output_out <= '0;
      sysref_output_complement_out <= '1;
      lvds_crosspoint_level_out <= '0;
    end else begin
      for (int i = 0; i < `SYSREF_OUTPUTS; i++) begin
        if (powerdown_q) begin
          // Powered down: static low, no toggling
          sysref_output_out[i] <= 1'b0;
          sysref_output_complement_out[i] <= 1'b1;
          lvds_crosspoint_level_out[i] <= 1'b0;
        end else if (out_lvpecl_in[i]) begin
          // LVPECL ignores the global bias select; idle low, then follow
          sysref_output_out[i] <= armed_q ? sysref_in : 1'b0;
          sysref_output_complement_out[i] <= armed_q ? !sysref_in : 1'b1;
          lvds_crosspoint_level_out[i] <= 1'b0;
        end else if (out_bias_in[i]) begin
          // Held static for the whole SYSREF event
          sysref_output_out[i] <= 1'b0;
          sysref_output_complement_out[i] <= 1'b1;
          lvds_crosspoint_level_out[i] <= bias_type_q;
        end else if (armed_q || rise) begin
          // Switching starts on the first rising edge itself
          sysref_output_out[i] <= sysref_in;
          sysref_output_complement_out[i] <= !sysref_in;
          lvds_crosspoint_level_out[i] <= 1'b0;
        end else begin
          // Idle before the first edge: low or crosspoint per global select
          sysref_output_out[i] <= 1'b0;
          sysref_output_complement_out[i] <= 1'b1;
          lvds_crosspoint_level_out[i] <= bias_type_q;
        end
      end
    end
  end

  // Calibration handshake: trigger pends until the block reports done
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_state_q <= CAL_IDLE;
      calib_start_out <= 1'b0;
      calib_trigger_pending_out <= 1'b0;
      calib_result_out <= 15'h0000;
    end else begin
      calib_start_out <= 1'b0;
      case (cal_state_q)
        CAL_IDLE: begin
          if (calib_trigger_in) begin
            cal_state_q <= CAL_START;
            calib_start_out <= 1'b1;
            calib_trigger_pending_out <= 1'b1;
          end
        end
        CAL_START: begin
          cal_state_q <= CAL_RUN;
        end
        CAL_RUN: begin
          if (calib_done_in) begin
            // Result latched and the trigger self-clears together
            cal_state_q <= CAL_IDLE;
            calib_result_out <= calib_code_in;
            calib_trigger_pending_out <= 1'b0;
          end
        end
        default: begin
          cal_state_q <= CAL_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: verification/sysref_ctrl_chk.sv */
// Purpose: Port assertions for the SYSREF control register block.
// Assumes: One-cycle strobes; field outputs land two edges after a write.
// Notes:   Output 0 stands in for the LVDS leg checks, output 1 for LVPECL.
`timescale 1ns/1ps
`include "sysref_ctrl_map.svh"
module sysref_ctrl_chk (
  // Clock, reset and register port
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  // SYSREF path
  input wire logic [`SYSREF_OUTPUTS-1:0] out_bias_in,
  input wire logic [`SYSREF_OUTPUTS-1:0] out_lvpecl_in,
  input wire logic sysref_in,
  input wire logic [`SYSREF_OUTPUTS-1:0] sysref_output_out,
  input wire logic [`SYSREF_OUTPUTS-1:0] sysref_output_complement_out,
  input wire logic [`SYSREF_OUTPUTS-1:0] lvds_crosspoint_level_out,
  // Static controls
  input wire logic sysref_global_powerdown_out,
  input wire logic [2:0] sysref_delay_step_units_out,
  input wire logic [8:0] calib_loop_feedback_divider_out,
  input wire logic [6:0] calib_loop_input_divider_out,
  input wire logic [5:0] align_ref_divide_out,
  // Calibration handshake
  input wire logic calib_trigger_in,
  input wire logic calib_done_in,
  input wire logic [14:0] calib_code_in,
  input wire logic calib_start_out,
  input wire logic calib_trigger_pending_out,
  input wire logic [14:0] calib_result_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Write strobes decoded per register
  wire wr_pwr = cfg_wr_in && cfg_addr_in == 8'h18;
  wire wr_bdc = cfg_wr_in && cfg_addr_in == 8'h19;
  wire wr_fbl = cfg_wr_in && cfg_addr_in == 8'h1A;
  wire wr_aid = cfg_wr_in && cfg_addr_in == 8'h1B;
  // Power-down must hold for two samples, since the copy may lag the register
  sequence s_lvds_rise;
    !sysref_in ##1 (sysref_in && !out_bias_in[0] && !out_lvpecl_in[0]
      && !sysref_global_powerdown_out) ##1 !sysref_global_powerdown_out;
  endsequence
  sequence s_trig_idle;
    calib_trigger_in && !calib_trigger_pending_out;
  endsequence
  a_pd_write: assert property (wr_pwr |-> ##2 sysref_global_powerdown_out == $past(cfg_wdata_in[7], 2)) else $error("power-down field wrong");
  a_pd_legs_low: assert property (sysref_global_powerdown_out && $past(sysref_global_powerdown_out) |-> !sysref_output_out[0] && sysref_output_complement_out[0] && !lvds_crosspoint_level_out[0]) else $error("legs not off in power-down");
  a_step_units: assert property (wr_bdc |-> ##2 sysref_delay_step_units_out == {1'b0, $past(cfg_wdata_in[6:5], 2)} + 3'h1) else $error("step units wrong");
  a_fbdiv_msb: assert property (wr_bdc |-> ##2 calib_loop_feedback_divider_out[8] == $past(cfg_wdata_in[0], 2)) else $error("feedback msb wrong");
  a_fbdiv_low: assert property (wr_fbl |-> ##2 calib_loop_feedback_divider_out[7:0] == $past(cfg_wdata_in, 2)) else $error("feedback low wrong");
  a_indiv_write: assert property (wr_aid |-> ##2 calib_loop_input_divider_out == $past(cfg_wdata_in[6:0], 2)) else $error("input divider wrong");
  a_align_ratio: assert property (wr_aid |-> ##2 align_ref_divide_out == ($past(cfg_wdata_in[7], 2) ? 6'h30 : 6'h18)) else $error("align ratio wrong");
  a_bias_static: assert property ($past(!sysref_global_powerdown_out && out_bias_in[0] && !out_lvpecl_in[0]) |-> !sysref_output_out[0] && sysref_output_complement_out[0]) else $error("biased leg toggled");
  a_rise_follow: assert property (s_lvds_rise |-> sysref_output_out[0] && !sysref_output_complement_out[0] && !lvds_crosspoint_level_out[0]) else $error("leg not following");
  a_pecl_no_xp: assert property ($past(out_lvpecl_in[1]) |-> !lvds_crosspoint_level_out[1]) else $error("crosspoint on LVPECL");
  a_calib_start: assert property (s_trig_idle |=> calib_start_out && calib_trigger_pending_out ##1 !calib_start_out) else $error("start pulse wrong");
  a_calib_done: assert property (calib_trigger_pending_out && !calib_start_out && calib_done_in |=> !calib_trigger_pending_out && calib_result_out == $past(calib_code_in)) else $error("result not stored");
endmodule
bind sysref_delay_calibration_ctrl sysref_ctrl_chk chk_i (.*);

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the SYSREF control register block.
// Assumes: Byte port strobes one cycle; field outputs two edges after write.
// Notes:   Output 0 is LVDS, output 1 LVPECL in the SYSREF tests.
`timescale 1ns/1ps
module testbench;
  // Stimulus, all given at time zero
  logic core_clk_in = 1'b0, rst_b_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0;
  logic sysref_in = 1'b0, calib_trigger_in = 1'b0, calib_done_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00, cfg_wdata_in = 8'h00, out_bias_in = 8'h00;
  logic [7:0] out_lvpecl_in = 8'h00;
  logic [14:0] calib_code_in = 15'h0000;
  // Observed outputs
  logic [7:0] cfg_rdata_out, sysref_output_out, sysref_output_complement_out;
  logic [7:0] lvds_crosspoint_level_out;
  logic cfg_rvalid_out, cfg_hit_out, sysref_global_powerdown_out;
  logic calib_start_out, calib_trigger_pending_out;
  logic [2:0] sysref_delay_step_units_out;
  logic [8:0] calib_loop_feedback_divider_out;
  logic [6:0] calib_loop_input_divider_out;
  logic [5:0] align_ref_divide_out;
  logic [14:0] calib_result_out;
  int mismatches = 0, tests_run = 0, cycles = 0;
  sysref_delay_calibration_ctrl sysref_delay_calibration_ctrl_i (.*);
  // 200 MHz clock
  always #2.5 core_clk_in = ~core_clk_in;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Settle a number of edges, then sample clear of the edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    cfg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b0;
  endtask
  // Read answer stands for one cycle after the taking edge, so look just after it
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(posedge core_clk_in);
    cfg_addr_in <= a;
    cfg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    chk("read", {1'b1, h, d}, {cfg_rvalid_out, cfg_hit_out, cfg_rdata_out});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 130 cycles the tests need
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(8'h18, 8'h00, 1'b1);
    rd(8'h19, 8'h00, 1'b1);
    rd(8'h1A, 8'h10, 1'b1);
    rd(8'h1B, 8'h08, 1'b1);
    rd(8'h1C, 8'h00, 1'b0);
    chk("defaults", {3'h1, 9'h010, 7'h08, 6'h18}, {sysref_delay_step_units_out, calib_loop_feedback_divider_out, calib_loop_input_divider_out, align_ref_divide_out});
    $display("test reset_values done");
    // Reserved bits are written as zero and must read back zero
    wr(8'h18, 8'h80);
    wr(8'h19, 8'hE1);
    wr(8'h1A, 8'hA5);
    wr(8'h1B, 8'hFF);
    wait_n(2);
    chk("fields", {1'b1, 3'h4, 9'h1A5, 7'h7F, 6'h30}, {sysref_global_powerdown_out, sysref_delay_step_units_out, calib_loop_feedback_divider_out, calib_loop_input_divider_out, align_ref_divide_out});
    rd(8'h18, 8'h80, 1'b1);
    rd(8'h19, 8'hE1, 1'b1);
    rd(8'h1B, 8'hFF, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(8'h19, {1'b0, s[1:0], 5'h00});
      wait_n(2);
      chk("step", {s[1:0] + 3'h1, 9'h0A5}, {sysref_delay_step_units_out, calib_loop_feedback_divider_out});
    end
    wr(8'h1B, 8'h08);
    // Output 1 turns LVPECL on the edge, ready for the SYSREF tests
    out_lvpecl_in <= 8'h02;
    wait_n(2);
    chk("align", {7'h08, 6'h18}, {calib_loop_input_divider_out, align_ref_divide_out});
    $display("test field_writes done");
    // Every bias type and per-output bias pair on LVDS output 0; LVPECL output 1 sees each bias type with its per-output bias off
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, 8'h80);
      wait_n(2);
      chk("pd_legs", 6'h0C, {sysref_output_out[1:0], sysref_output_complement_out[1:0], lvds_crosspoint_level_out[1:0]});
      wr(8'h19, {m[1], 7'h00});
      out_bias_in <= {7'h00, m[0]};
      wr(8'h18, 8'h00);
      wait_n(3);
      chk("idle", {4'h3, 1'b0, m[1]}, {sysref_output_out[1:0], sysref_output_complement_out[1:0], lvds_crosspoint_level_out[1:0]});
      @(posedge core_clk_in);
      sysref_in <= 1'b1;
      wait_n(2);
      chk("event", {1'b1, !m[0], 1'b0, m[0], 1'b0, m[0] & m[1]}, {sysref_output_out[1:0], sysref_output_complement_out[1:0], lvds_crosspoint_level_out[1:0]});
      @(posedge core_clk_in);
      sysref_in <= 1'b0;
      wait_n(2);
      chk("fall", {4'h3, 1'b0, m[0] & m[1]}, {sysref_output_out[1:0], sysref_output_complement_out[1:0], lvds_crosspoint_level_out[1:0]});
    end
    $display("test sysref_bias done");
    // Trigger, a stray trigger while busy, done, then a done while idle
    @(posedge core_clk_in);
    calib_trigger_in <= 1'b1;
    @(posedge core_clk_in);
    calib_trigger_in <= 1'b0;
    // Start pulse stands only one cycle, so look just after the taking edge
    #1;
    chk("start", 2'h3, {calib_start_out, calib_trigger_pending_out});
    @(posedge core_clk_in);
    calib_trigger_in <= 1'b1;
    @(posedge core_clk_in);
    calib_trigger_in <= 1'b0;
    calib_done_in <= 1'b1;
    calib_code_in <= 15'h7ABC;
    @(posedge core_clk_in);
    calib_done_in <= 1'b0;
    wait_n(1);
    chk("result", {2'h0, 15'h7ABC}, {calib_start_out, calib_trigger_pending_out, calib_result_out});
    @(posedge core_clk_in);
    calib_done_in <= 1'b1;
    calib_code_in <= 15'h1111;
    @(posedge core_clk_in);
    calib_done_in <= 1'b0;
    wait_n(1);
    chk("idle_done", 15'h7ABC, calib_result_out);
    $display("test calibration done");
    tally_and_finish();
  end
endmodule
